// [dv/dbc_bridge_ctrl_chk.sv]
`timescale 1ns/1ns
module dbc_bridge_ctrl_chk
	import dbc_pkg::*;
(
	// clock and reset
	input wire logic                  CLK,
	input wire logic                  RST,
	// config access
	input wire logic                  CFG_PORT0,
	input wire logic                  CFG_WR,
	input wire logic                  CFG_RD,
	input wire logic [15:0]           CFG_RDATA,
	input wire logic                  CFG_HIT,
	// error path
	input wire logic [1:0]            CMD_ERR_ESC,
	input wire logic [1:0]            SEC_ERR_MSG,
	input wire logic [1:0]            ERR_FWD,
	input wire logic [1:0]            SYS_ERR_SET,
	// forwarding query
	input wire logic                  REQ_VALID,
	input wire dbc_pkg::dbc_kind_type REQ_KIND,
	input wire logic                  FWD_VALID,
	input wire logic                  FWD_OK
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	AST_HIT_SRC: assert property (CFG_HIT |-> $past(CFG_PORT0 && (CFG_WR || CFG_RD)))
		else $error("hit without port 0 access");
	AST_RSVD_ZERO: assert property (CFG_RDATA[0] == 1'h0 && CFG_RDATA[15:5] == 11'h000)
		else $error("reserved bits read nonzero");
	AST_RD_IDLE: assert property (!$past(CFG_RD) |-> CFG_RDATA == 16'h0000)
		else $error("read data outside read slot");
	AST_ERR_SRC: assert property ((ERR_FWD & ~$past(SEC_ERR_MSG)) == 2'h0)
		else $error("error forwarded without message");
	AST_SYS_SRC: assert property ((SYS_ERR_SET & ~(ERR_FWD & $past(CMD_ERR_ESC))) == 2'h0)
		else $error("system error set without cause");
	AST_SYS_ON: assert property (ERR_FWD[0] && $past(CMD_ERR_ESC[0]) |-> SYS_ERR_SET[0])
		else $error("system error not set");
	AST_FWD_LAT: assert property (REQ_VALID |=> FWD_VALID)
		else $error("verdict missing one cycle after query");
	AST_FWD_KIND: assert property (FWD_OK |-> $past(REQ_VALID && REQ_KIND != DBC_REQ_OTHER))
		else $error("forward granted without valid query");
endmodule

// [dv/dbc_bridge_ctrl_tb.sv]
`timescale 1ns/1ns
module dbc_bridge_ctrl_tb;
	import dbc_pkg::*;
	logic        CLK = 1'h0, RST = 1'h1, CFG_PORT0 = 1'h1, CFG_WR = 1'h0, CFG_RD = 1'h0;
	logic        REQ_VALID = 1'h0, REQ_PORT = 1'h0, REQ_IN_IO_WIN = 1'h0, REQ_IN_MEM_WIN = 1'h0;
	logic        CFG_HIT, FWD_VALID, FWD_OK;
	logic [1:0]  CFG_BE = 2'h3, CMD_ERR_ESC = 2'h3, CMD_IO_EN = 2'h3, CMD_MEM_EN = 2'h3;
	logic [1:0]  SEC_ERR_MSG = 2'h0, ERR_FWD, SYS_ERR_SET;
	logic [11:0] CFG_ADDR = 12'hE2A;
	logic [15:0] CFG_WDATA = 16'h0000, CFG_RDATA;
	logic [31:0] REQ_ADDR = 32'h00000000;
	dbc_kind_type REQ_KIND = DBC_REQ_MEM;
	dbc_dir_type  REQ_DIR = DBC_DIR_DOWN;
	int          failures = 0, n_checks = 0, cyc = 0;

	dbc_bridge_ctrl dbc_bridge_ctrl_i (.*);
	always #4 CLK = ~CLK;

	// run is about a hundred cycles; the ceiling only catches a hang
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			finish_test;
		end
	end
	////////////////////////////////////////////////////////////////
	task finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(string n, logic [15:0] s, logic [15:0] e);
		n_checks++;
		if (s !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// read compares data; write only the hit
	task acc(logic wr, logic p, logic [11:0] a, logic [15:0] d, logic h);
		@(posedge CLK);
		CFG_WR <= wr;
		CFG_RD <= !wr;
		CFG_PORT0 <= p;
		CFG_ADDR <= a;
		CFG_WDATA <= d;
		@(posedge CLK);
		CFG_WR <= 1'h0;
		CFG_RD <= 1'h0;
		#1 chk("cfg_hit", CFG_HIT, h);
		if (!wr)
			chk("cfg_rdata", CFG_RDATA, d);
	endtask
	task q(dbc_kind_type k, dbc_dir_type dr, logic [31:0] a, logic w, logic e);
		@(posedge CLK);
		REQ_VALID <= 1'h1;
		REQ_KIND <= k;
		REQ_DIR <= dr;
		REQ_ADDR <= a;
		REQ_IN_IO_WIN <= w;
		REQ_IN_MEM_WIN <= w;
		@(posedge CLK);
		REQ_VALID <= 1'h0;
		#1 chk("fwd_valid", FWD_VALID, 1'h1);
		chk("fwd_ok", FWD_OK, e);
	endtask
	task er(logic [1:0] m, logic [1:0] f, logic [1:0] s);
		@(posedge CLK);
		SEC_ERR_MSG <= m;
		@(posedge CLK);
		SEC_ERR_MSG <= 2'h0;
		#1 chk("err_fwd", ERR_FWD, f);
		chk("sys_err_set", SYS_ERR_SET, s);
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		acc(1'h0, 1'h1, 12'hE2A, 16'h0000, 1'h1);
		acc(1'h0, 1'h1, 12'hE2C, 16'h0000, 1'h1);
		acc(1'h1, 1'h1, 12'hE2A, 16'hFFFF, 1'h1);
		acc(1'h0, 1'h1, 12'hE2A, 16'h001E, 1'h1);
		acc(1'h1, 1'h0, 12'hE2C, 16'hFFFF, 1'h0);
		acc(1'h0, 1'h1, 12'hE2C, 16'h0000, 1'h1);
		acc(1'h0, 1'h1, 12'hE30, 16'h0000, 1'h0);
		// upper byte only: writable bits sit in the low byte, so nothing moves
		@(posedge CLK);
		CFG_BE <= 2'h2;
		acc(1'h1, 1'h1, 12'hE2A, 16'h0000, 1'h1);
		acc(1'h0, 1'h1, 12'hE2A, 16'h001E, 1'h1);
		@(posedge CLK);
		CFG_BE <= 2'h3;
	endtask
	// mid-run reset must clear both copies again
	task t_rst;
		@(posedge CLK);
		RST <= 1'h1;
		repeat (2) @(posedge CLK);
		RST <= 1'h0;
		acc(1'h0, 1'h1, 12'hE2A, 16'h0000, 1'h1);
		acc(1'h0, 1'h1, 12'hE2C, 16'h0000, 1'h1);
	endtask
	task t_err;
		er(2'h3, 2'h1, 2'h1);
		@(posedge CLK);
		CMD_ERR_ESC <= 2'h2;
		er(2'h1, 2'h1, 2'h0);
		acc(1'h1, 1'h1, 12'hE2C, 16'h0002, 1'h1);
		er(2'h2, 2'h2, 2'h2);
	endtask
	task t_fwd;
		acc(1'h1, 1'h1, 12'hE2A, 16'h0004, 1'h1);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h00000100, 1'h1, 1'h0);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h00000400, 1'h1, 1'h1);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h00010100, 1'h1, 1'h1);
		q(DBC_REQ_IO, DBC_DIR_UP, 32'h000007FF, 1'h1, 1'h1);
		acc(1'h1, 1'h1, 12'hE2A, 16'h0010, 1'h1);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h00000100, 1'h1, 1'h1);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h000003B4, 1'h0, 1'h0);
		q(DBC_REQ_MEM, DBC_DIR_DOWN, 32'h000A0000, 1'h1, 1'h1);
		acc(1'h1, 1'h1, 12'hE2A, 16'h000C, 1'h1);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h000007B4, 1'h0, 1'h1);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h000003DF, 1'h1, 1'h1);
		q(DBC_REQ_MEM, DBC_DIR_DOWN, 32'h000BFFFF, 1'h0, 1'h1);
		q(DBC_REQ_MEM, DBC_DIR_UP, 32'h000A0000, 1'h0, 1'h0);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h000103B0, 1'h0, 1'h0);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h000003BC, 1'h0, 1'h0);
		q(DBC_REQ_OTHER, DBC_DIR_DOWN, 32'h000003B0, 1'h1, 1'h0);
		acc(1'h1, 1'h1, 12'hE2A, 16'h0018, 1'h1);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h000007B4, 1'h0, 1'h0);
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h000003C0, 1'h0, 1'h1);
		@(posedge CLK);
		CMD_IO_EN <= 2'h2;
		q(DBC_REQ_MEM, DBC_DIR_DOWN, 32'h000A0000, 1'h0, 1'h0);
		@(posedge CLK);
		REQ_PORT <= 1'h1;
		q(DBC_REQ_IO, DBC_DIR_DOWN, 32'h000003B4, 1'h0, 1'h0);
		acc(1'h1, 1'h1, 12'hE2C, 16'h0008, 1'h1);
		q(DBC_REQ_MEM, DBC_DIR_DOWN, 32'h000A0000, 1'h0, 1'h1);
		@(posedge CLK);
		CMD_MEM_EN <= 2'h1;
		q(DBC_REQ_MEM, DBC_DIR_DOWN, 32'h000A0000, 1'h0, 1'h0);
		q(DBC_REQ_MEM, DBC_DIR_UP, 32'h00100000, 1'h0, 1'h1);
	endtask

	initial
	begin
		repeat (8) @(posedge CLK);
		RST <= 1'h0;
		t_regs;
		t_err;
		t_fwd;
		t_rst;
		finish_test;
	end
endmodule

bind dbc_bridge_ctrl dbc_bridge_ctrl_chk dbc_bridge_ctrl_chk_i (.CLK, .RST, .CFG_PORT0, .CFG_WR,
	.CFG_RD, .CFG_RDATA, .CFG_HIT, .CMD_ERR_ESC, .SEC_ERR_MSG, .ERR_FWD, .SYS_ERR_SET,
	.REQ_VALID, .REQ_KIND, .FWD_VALID, .FWD_OK);

// [hw/dbc_bridge_ctrl.sv]
`timescale 1ns/1ns
`include "dbc_params.svh"
module dbc_bridge_ctrl
	import dbc_pkg::*;
(
	// clock and reset
	input  wire logic                 CLK,
	input  wire logic                 RST,
	// port 0 configuration access
	input  wire logic                 CFG_PORT0,
	input  wire logic [11:0]          CFG_ADDR,
	input  wire logic                 CFG_WR,
	input  wire logic                 CFG_RD,
	input  wire logic [1:0]           CFG_BE,
	input  wire logic [15:0]          CFG_WDATA,
	output logic [15:0]               CFG_RDATA,
	output logic                      CFG_HIT,
	// command register bits of ports 5 and 6
	input  wire logic [1:0]           CMD_ERR_ESC,
	input  wire logic [1:0]           CMD_IO_EN,
	input  wire logic [1:0]           CMD_MEM_EN,
	// error messages arriving on the secondary side
	input  wire logic [1:0]           SEC_ERR_MSG,
	output logic [1:0]                ERR_FWD,
	output logic [1:0]                SYS_ERR_SET,
	// forwarding query
	input  wire logic                 REQ_VALID,
	input  wire logic                 REQ_PORT,
	input  wire dbc_pkg::dbc_kind_type REQ_KIND,
	input  wire dbc_pkg::dbc_dir_type  REQ_DIR,
	input  wire logic [31:0]          REQ_ADDR,
	input  wire logic                 REQ_IN_IO_WIN,
	input  wire logic                 REQ_IN_MEM_WIN,
	output logic                      FWD_VALID,
	output logic                      FWD_OK
);

	////////////////////////////////////////////////////////////////////////////

	function automatic logic [15:0] merge_wr(input logic [15:0] old, input logic [15:0] d,
		input logic [1:0] be);
		logic [15:0] m;
		m = {{8{be[1]}}, {8{be[0]}}} & `DBC_WR_MASK;
		merge_wr = (old & ~m) | (d & m);
	endfunction

	logic [15:0] ctrl_r [2];
	logic        sel_p5;
	logic        sel_p6;

	always_comb
	begin
		// only port 0 space reaches these copies
		sel_p5 = CFG_PORT0 && CFG_ADDR == `DBC_OFS_P5_BRIDGE_CTRL;
		sel_p6 = CFG_PORT0 && CFG_ADDR == `DBC_OFS_P6_BRIDGE_CTRL;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ctrl_r[0] <= `DBC_CTRL_RESET;
			ctrl_r[1] <= `DBC_CTRL_RESET;
		end
		else if (CFG_WR)
		begin
			if (sel_p5)
				ctrl_r[0] <= merge_wr(ctrl_r[0], CFG_WDATA, CFG_BE);
			if (sel_p6)
				ctrl_r[1] <= merge_wr(ctrl_r[1], CFG_WDATA, CFG_BE);
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			CFG_RDATA <= 16'h0000;
			CFG_HIT   <= 1'b0;
		end
		else
		begin
			CFG_HIT <= (CFG_RD || CFG_WR) && (sel_p5 || sel_p6);
			// unmapped reads return zero
			if (CFG_RD && sel_p5)
				CFG_RDATA <= ctrl_r[0] & `DBC_WR_MASK;
			else if (CFG_RD && sel_p6)
				CFG_RDATA <= ctrl_r[1] & `DBC_WR_MASK;
			else
				CFG_RDATA <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ERR_FWD     <= 2'h0;
			SYS_ERR_SET <= 2'h0;
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				ERR_FWD[p]     <= SEC_ERR_MSG[p] && ctrl_r[p][`DBC_BIT_ERR_ESC];
				SYS_ERR_SET[p] <= SEC_ERR_MSG[p] && ctrl_r[p][`DBC_BIT_ERR_ESC]
					&& CMD_ERR_ESC[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////

	dbc_ctrl_if ctl ();
	logic       fwd_c;

	// one shared decoder; port select steers the control copy in
	assign ctl.err_esc    = ctrl_r[REQ_PORT][`DBC_BIT_ERR_ESC];
	assign ctl.alias_filt = ctrl_r[REQ_PORT][`DBC_BIT_ALIAS_FILT];
	assign ctl.disp_dec   = ctrl_r[REQ_PORT][`DBC_BIT_DISP_DEC];
	// bit 4 has no effect without bit 3
	assign ctl.disp_16    = ctrl_r[REQ_PORT][`DBC_BIT_DISP_16]
		&& ctrl_r[REQ_PORT][`DBC_BIT_DISP_DEC];
	assign ctl.io_en      = CMD_IO_EN[REQ_PORT];
	assign ctl.mem_en     = CMD_MEM_EN[REQ_PORT];

	dbc_fwd_decode u_dec
	(
		.ctl        (ctl),
		.kind       (REQ_KIND),
		.dir        (REQ_DIR),
		.addr       (REQ_ADDR),
		.in_io_win  (REQ_IN_IO_WIN),
		.in_mem_win (REQ_IN_MEM_WIN),
		.fwd        (fwd_c)
	);

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			FWD_VALID <= 1'b0;
			FWD_OK    <= 1'b0;
		end
		else
		begin
			FWD_VALID <= REQ_VALID;
			FWD_OK    <= REQ_VALID && fwd_c;
		end
	end

endmodule

// [hw/dbc_ctrl_if.sv]
`timescale 1ns/1ns
interface dbc_ctrl_if;
	logic       err_esc;
	logic       alias_filt;
	logic       disp_dec;
	logic       disp_16;
	logic       io_en;
	logic       mem_en;

	modport regs (output err_esc, output alias_filt, output disp_dec, output disp_16,
		output io_en, output mem_en);
	modport dec  (input err_esc, input alias_filt, input disp_dec, input disp_16,
		input io_en, input mem_en);
endinterface

// [hw/dbc_fwd_decode.sv]
`timescale 1ns/1ns
`include "dbc_params.svh"
module dbc_fwd_decode
	import dbc_pkg::*;
(
	// control bits of one port
	dbc_ctrl_if.dec             ctl,
	// request under test
	input  wire dbc_kind_type   kind,
	input  wire dbc_dir_type    dir,
	input  wire logic [31:0]    addr,
	input  wire logic           in_io_win,
	input  wire logic           in_mem_win,
	// verdict
	output logic                fwd
);

	function automatic logic disp_io_hit(input logic [31:0] a, input logic w16);
		logic [9:0] lo;
		lo = a[9:0];
		disp_io_hit = (a[31:16] == 16'h0000)
			&& (!w16 || a[15:10] == 6'h00)
			&& ((lo >= `DBC_DISP_IO1_LO && lo <= `DBC_DISP_IO1_HI)
			|| (lo >= `DBC_DISP_IO2_LO && lo <= `DBC_DISP_IO2_HI));
	endfunction

	logic disp_mem;
	logic disp_io;
	logic alias_zone;
	logic alias_top;

	always_comb
	begin
		disp_mem   = addr >= `DBC_DISP_MEM_LO && addr <= `DBC_DISP_MEM_HI;
		disp_io    = ctl.disp_dec && disp_io_hit(addr, ctl.disp_16);
		alias_zone = ctl.alias_filt && in_io_win && addr[31:16] == `DBC_IO_64K_TOP;
		alias_top  = addr[9:0] >= `DBC_ALIAS_LOW_BYTES;
		fwd        = 1'b0;
		case (kind)
			DBC_REQ_MEM:
			begin
				if (ctl.disp_dec && disp_mem)
					// window-independent claim, needs both space enables
					fwd = (dir == DBC_DIR_DOWN) && ctl.io_en && ctl.mem_en;
				else if (dir == DBC_DIR_DOWN)
					fwd = in_mem_win && ctl.mem_en;
				else
					fwd = !in_mem_win;
			end
			DBC_REQ_IO:
			begin
				if (disp_io)
					fwd = (dir == DBC_DIR_DOWN) && ctl.io_en && ctl.mem_en;
				else if (dir == DBC_DIR_DOWN)
					fwd = in_io_win && ctl.io_en && !(alias_zone && alias_top);
				else
					fwd = !in_io_win || (alias_zone && alias_top);
			end
			default:
				fwd = 1'b0;
		endcase
	end

endmodule

// [hw/dbc_params.svh]
`ifndef DBC_PARAMS_SVH
`define DBC_PARAMS_SVH

// register offsets inside port 0 configuration space
`define DBC_OFS_P5_BRIDGE_CTRL   12'hE2A
`define DBC_OFS_P6_BRIDGE_CTRL   12'hE2C

// bridge control field positions
`define DBC_BIT_ERR_ESC          1
`define DBC_BIT_ALIAS_FILT       2
`define DBC_BIT_DISP_DEC         3
`define DBC_BIT_DISP_16          4
`define DBC_WR_MASK              16'h001E
`define DBC_CTRL_RESET           16'h0000

// legacy address ranges
`define DBC_DISP_MEM_LO          32'h000A0000
`define DBC_DISP_MEM_HI          32'h000BFFFF
`define DBC_DISP_IO1_LO          10'h3B0
`define DBC_DISP_IO1_HI          10'h3BB
`define DBC_DISP_IO2_LO          10'h3C0
`define DBC_DISP_IO2_HI          10'h3DF
`define DBC_IO_64K_TOP           16'h0000
`define DBC_ALIAS_LOW_BYTES      10'h100

`endif

// [hw/dbc_pkg.sv]
package dbc_pkg;

	typedef enum logic [1:0]
	{
		DBC_REQ_MEM,
		DBC_REQ_IO,
		DBC_REQ_OTHER
	} dbc_kind_type;

	typedef enum logic
	{
		DBC_DIR_DOWN,
		DBC_DIR_UP
	} dbc_dir_type;

endpackage
